// >>> src/tmrc_timer.sv
// sixteen-bit timer/counter with prescaler, wide access and overflow irq
// assumes strobes and compare inputs on CORE_CLK, pins and oscillator async
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "tmrc_defines.svh"

// Notes on behaviour
// - control bit 7 selects coherent sixteen-bit access
// - two select bits route time base to compare modules
// - prescale bits 5-4 divide by 1, 2, 4, 8
// - sync-disable bit set chooses unsynchronised external counting
// - source bit: instruction cycle or external rising edge
// - run bit 0 gates counting, value held
// - wide mode: low read latches high into buffer
// - wide mode: high write buffered, applied with low
// - low byte write clears prescaler; high does not
// - oscillator enabled forces pins input, reads zero
// - counts up, wraps, sticky overflow flag
// - overflow irq only while enable bit 1 set
// - special-event compare match zeroes count except in unsynchronised external mode, starts conversion if converter enabled
// - software count write beats special-event reset
// - special-event reset never raises overflow flag
module tmrc_timer (
	input wire logic CORE_CLK, // instruction clock
	input wire logic RSTN, // async reset, active low
	input wire logic CE, // clock enable, freezes everything when low
	input wire logic [`TMRC_ADDR_W-1:0] ADDR, // register index
	input wire logic [7:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [7:0] RDATA, // read data, cycle after read strobe
	output logic IRQ, // level interrupt
	input wire logic EXTERNAL_COUNT_PIN, // async external clock pin
	input wire logic SHARED_OSC_CLK, // async shared oscillator output
	input wire logic SHARED_OSCILLATOR_ENABLE, // from other timer control
	input wire logic [3:0] COMPARE_MODE, // second compare module mode
	input wire logic COMPARE_MATCH, // compare match pulse
	input wire logic CONVERTER_ENABLE, // converter is enabled
	output logic CONVERT_START, // one-cycle conversion start
	output logic TB_ENHANCED_SEL, // high: this timer feeds enhanced module
	output logic TB_STANDARD_SEL, // high: this timer feeds standard module
	input wire logic [1:0] PORT_DIRECTION_BITS, // port direction, 1 is input
	input wire logic [1:0] PORT_PIN_LEVEL, // async levels of the two pins
	output logic [1:0] PIN_DIRECTION, // effective direction, 1 is input
	output logic [1:0] PIN_READ, // value software reads from the pins
	output logic [15:0] COUNT_VALUE // live count for compare modules
);
	import tmrc_pkg::*;

	// all state lives in one register word
	tmrc_state_t s;
	tmrc_state_t next_s;

	logic wide;
	logic [1:0] prescale_sel;
	logic sync_disable;
	logic clock_source;
	logic run;
	logic [2:0] prescale_mask;
	logic src_level;
	logic src_rise;
	logic src_fall;
	logic pre_in;
	logic pre_tick;
	logic inc;
	logic special_hit;
	logic special_reset;
	logic wr_low;
	logic wr_high;
	logic rd_low;
	logic count_written;
	logic count_at_max;
	logic overflow_set;
	logic special_mode;
	logic sel_control;
	logic sel_count_low;
	logic sel_count_high;
	logic sel_flags;
	logic sel_flag_clear;
	logic sel_enables;
	logic [7:0] next_control;
	logic [7:0] read_word;
	logic [1:0] pin_dir_eff;
	logic [1:0] pin_read_eff;

	assign wide = s.control[`TMRC_BIT_WIDE_ACCESS];
	assign prescale_sel = {s.control[`TMRC_BIT_PRESCALE_HI], s.control[`TMRC_BIT_PRESCALE_LO]};
	assign sync_disable = s.control[`TMRC_BIT_SYNC_DISABLE];
	assign clock_source = s.control[`TMRC_BIT_CLOCK_SOURCE];
	assign run = s.control[`TMRC_BIT_RUN_ENABLE];

	// one mask bit per prescale stage in use
	always_comb
	begin
		case (prescale_sel)
			2'h3: prescale_mask = 3'h7;
			2'h2: prescale_mask = 3'h3;
			2'h1: prescale_mask = 3'h1;
			default: prescale_mask = 3'h0;
		endcase
	end

	// one select per register index; unmapped indices select nothing
	always_comb
	begin
		sel_control = 1'b0;
		sel_count_low = 1'b0;
		sel_count_high = 1'b0;
		sel_flags = 1'b0;
		sel_flag_clear = 1'b0;
		sel_enables = 1'b0;
		if (ADDR == `TMRC_ADDR_CONTROL)
		begin
			sel_control = 1'b1;
		end
		else if (ADDR == `TMRC_ADDR_COUNT_LOW)
		begin
			sel_count_low = 1'b1;
		end
		else if (ADDR == `TMRC_ADDR_COUNT_HIGH)
		begin
			sel_count_high = 1'b1;
		end
		else if (ADDR == `TMRC_ADDR_FLAGS)
		begin
			sel_flags = 1'b1;
		end
		else if (ADDR == `TMRC_ADDR_FLAG_CLEAR)
		begin
			sel_flag_clear = 1'b1;
		end
		else if (ADDR == `TMRC_ADDR_ENABLES)
		begin
			sel_enables = 1'b1;
		end
	end

	assign wr_low = WR && sel_count_low;
	assign wr_high = WR && sel_count_high;
	assign rd_low = RD && sel_count_low;
	// a high write in wide mode only touches the buffer
	assign count_written = wr_low || (wr_high && !wide);

	// source chosen only after both inputs are synchronised
	assign src_level = SHARED_OSCILLATOR_ENABLE ? s.sync_second[1] : s.sync_second[0];
	// reset leaves src_last low, so the first rise comes unarmed and is not counted
	assign src_rise = src_level && !s.src_last;
	assign src_fall = !src_level && s.src_last;

	// internal source feeds every instruction cycle, external only armed rises
	assign pre_in = run && (clock_source ? (s.armed && src_rise) : 1'b1);
	assign pre_tick = pre_in && ((s.prescale | ~prescale_mask) == `TMRC_PRESCALE_FULL);

	// synchronised mode adds the two-stage chain; unsynchronised counts at once
	always_comb
	begin
		if (clock_source && !sync_disable)
		begin
			inc = s.delay_second && run;
		end
		else
		begin
			inc = pre_tick;
		end
	end

	assign special_mode = (COMPARE_MODE == `TMRC_SPECIAL_EVENT_MODE);
	assign special_hit = COMPARE_MATCH && special_mode;
	// unsynchronised counting cannot take the reset reliably, so it is dropped
	assign special_reset = special_hit && !(clock_source && sync_disable);

	// natural wrap only: writes and the special event both pre-empt the step
	assign count_at_max = (s.count == `TMRC_COUNT_MAX);
	assign overflow_set = inc && !count_written && !special_reset && count_at_max;

	// control after this edge, so the routing outputs need no extra lag
	always_comb
	begin
		next_control = s.control;
		if (WR && sel_control)
		begin
			next_control = WDATA;
		end
	end

	// read multiplexer; live high byte hidden behind the buffer in wide mode
	always_comb
	begin
		read_word = 8'h00;
		if (sel_control)
		begin
			read_word = s.control;
		end
		else if (sel_count_low)
		begin
			read_word = s.count[7:0];
		end
		else if (sel_count_high)
		begin
			read_word = wide ? s.high_buffer : s.count[15:8];
		end
		else if (sel_flags)
		begin
			read_word[`TMRC_BIT_OVERFLOW] = s.overflow_flag;
		end
		else if (sel_enables)
		begin
			read_word[`TMRC_BIT_OVERFLOW] = s.overflow_irq_enable;
		end
	end

	// each pin turns input and reads low while the oscillator owns it
	for (genvar p = 0; p < 2; p++)
	begin : g_pin
		assign pin_dir_eff[p] = SHARED_OSCILLATOR_ENABLE || PORT_DIRECTION_BITS[p];
		assign pin_read_eff[p] = !SHARED_OSCILLATOR_ENABLE && s.sync_second[p + 2];
	end

	always_comb
	begin
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.convert_start = 1'b0;

		// pin synchronisers, first stage read only by the second
		next_s.sync_first = {PORT_PIN_LEVEL, SHARED_OSC_CLK, EXTERNAL_COUNT_PIN};
		next_s.sync_second = s.sync_first;
		next_s.src_last = src_level;

		// arm on the first falling edge after the external source is chosen
		if (!clock_source)
		begin
			next_s.armed = 1'b0;
		end
		else if (src_fall)
		begin
			next_s.armed = 1'b1;
		end

		// delay chain only runs in synchronised external mode
		next_s.delay_first = clock_source && !sync_disable && pre_tick;
		next_s.delay_second = s.delay_first;

		// prescaler
		if (pre_tick)
		begin
			next_s.prescale = 3'h0;
		end
		else if (pre_in)
		begin
			next_s.prescale = s.prescale + 3'h1;
		end

		// count: software write, then special event, then increment
		if (count_written)
		begin
			if (wr_low)
			begin
				next_s.count[7:0] = WDATA;
				next_s.prescale = 3'h0;
				if (wide)
				begin
					next_s.count[15:8] = s.high_buffer;
				end
			end
			else
			begin
				next_s.count[15:8] = WDATA;
			end
		end
		else if (special_reset)
		begin
			// no overflow flag on this path
			next_s.count = `TMRC_COUNT_RESET;
			next_s.prescale = 3'h0;
			next_s.delay_first = 1'b0;
			next_s.delay_second = 1'b0;
		end
		else if (inc)
		begin
			next_s.count = s.count + 16'h0001;
			if (count_at_max)
			begin
				next_s.overflow_flag = 1'b1;
			end
		end

		if (special_hit && CONVERTER_ENABLE)
		begin
			next_s.convert_start = 1'b1;
		end

		// register writes; flags and unmapped indices ignore writes
		if (WR)
		begin
			if (sel_control)
			begin
				next_s.control = next_control;
			end
			else if (sel_count_high)
			begin
				if (wide)
				begin
					next_s.high_buffer = WDATA;
				end
			end
			else if (sel_flag_clear)
			begin
				// an overflow in the same cycle keeps the flag set
				if (WDATA[`TMRC_BIT_OVERFLOW] && !overflow_set)
				begin
					next_s.overflow_flag = 1'b0;
				end
			end
			else if (sel_enables)
			begin
				next_s.overflow_irq_enable = WDATA[`TMRC_BIT_OVERFLOW];
			end
		end

		// register reads, data stand one cycle
		if (RD)
		begin
			next_s.rdata = read_word;
		end
		if (rd_low && wide)
		begin
			// latch high with the low read so the pair cannot tear on rollover
			next_s.high_buffer = s.count[15:8];
		end

		// irq from the next flag so the pin tracks the flag without lag
		next_s.irq = next_s.overflow_flag && next_s.overflow_irq_enable;

		// code 1x both, 01 enhanced only, 00 neither
		next_s.tb_enhanced = next_control[`TMRC_BIT_TB_SEL_HI]
			|| next_control[`TMRC_BIT_TB_SEL_LO];
		next_s.tb_standard = next_control[`TMRC_BIT_TB_SEL_HI];

		next_s.pin_dir = pin_dir_eff;
		next_s.pin_read = pin_read_eff;
	end

	// whole state moves together; CE low freezes syncs and read data as well

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			s <= '0;
			s.control <= `TMRC_CONTROL_RESET;
			s.count <= `TMRC_COUNT_RESET;
		end
		else if (CE)
		begin
			s <= next_s;
		end
	end

	// every output is a field of the state register
	assign RDATA = s.rdata;
	assign IRQ = s.irq;
	assign CONVERT_START = s.convert_start;
	assign TB_ENHANCED_SEL = s.tb_enhanced;
	assign TB_STANDARD_SEL = s.tb_standard;
	assign PIN_DIRECTION = s.pin_dir;
	assign PIN_READ = s.pin_read;
	assign COUNT_VALUE = s.count;

endmodule : tmrc_timer

// >>> src/tmrc_defines.svh
// register indices, field positions, reset values and codes of the timer
// assumes the plain register port of the timer top module
`ifndef TMRC_DEFINES_SVH
`define TMRC_DEFINES_SVH

`define TMRC_ADDR_W 3
`define TMRC_ADDR_CONTROL 3'h0
`define TMRC_ADDR_COUNT_LOW 3'h1
`define TMRC_ADDR_COUNT_HIGH 3'h2
`define TMRC_ADDR_FLAGS 3'h3
`define TMRC_ADDR_FLAG_CLEAR 3'h4
`define TMRC_ADDR_ENABLES 3'h5

`define TMRC_BIT_WIDE_ACCESS 7
`define TMRC_BIT_TB_SEL_HI 6
`define TMRC_BIT_PRESCALE_HI 5
`define TMRC_BIT_PRESCALE_LO 4
`define TMRC_BIT_TB_SEL_LO 3
`define TMRC_BIT_SYNC_DISABLE 2
`define TMRC_BIT_CLOCK_SOURCE 1
`define TMRC_BIT_RUN_ENABLE 0
`define TMRC_BIT_OVERFLOW 1

`define TMRC_CONTROL_RESET 8'h00
`define TMRC_COUNT_RESET 16'h0000
`define TMRC_COUNT_MAX 16'hFFFF
`define TMRC_SPECIAL_EVENT_MODE 4'hB
`define TMRC_PRESCALE_FULL 3'h7

`endif

// >>> src/tmrc_pkg.sv
// types of the timer design, not imported by its bench
// constants live in tmrc_defines.svh
package tmrc_pkg;

	// whole state of the timer, registered as one word
	typedef struct packed {
		logic [7:0] control;
		logic [15:0] count;
		logic [7:0] high_buffer;
		logic [2:0] prescale;
		logic armed;
		logic src_last;
		logic [3:0] sync_first;
		logic [3:0] sync_second;
		logic delay_first;
		logic delay_second;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic irq;
		logic [7:0] rdata;
		logic convert_start;
		logic tb_enhanced;
		logic tb_standard;
		logic [1:0] pin_dir;
		logic [1:0] pin_read;
	} tmrc_state_t;

endpackage : tmrc_pkg

// >>> bench/tmrc_assertions.sv
// port checker of the timer
// assumes CE held high, bound below
`timescale 1ns/10ps
`include "tmrc_defines.svh"
module tmrc_assertions (
	input wire logic CORE_CLK, // clock
	input wire logic RSTN, // reset
	input wire logic [`TMRC_ADDR_W-1:0] ADDR, // index
	input wire logic [7:0] WDATA, // data
	input wire logic WR, // write
	input wire logic RD, // read
	input wire logic [7:0] RDATA, // read data
	input wire logic IRQ, // irq
	input wire logic SHARED_OSCILLATOR_ENABLE, // osc
	input wire logic [3:0] COMPARE_MODE, // mode
	input wire logic COMPARE_MATCH, // match
	input wire logic CONVERTER_ENABLE, // adc on
	input wire logic CONVERT_START, // start
	input wire logic TB_ENHANCED_SEL, // base
	input wire logic TB_STANDARD_SEL, // base
	input wire logic [1:0] PIN_DIRECTION, // dir
	input wire logic [1:0] PIN_READ, // pins
	input wire logic [15:0] COUNT_VALUE // count
);
	logic [7:0] ctl;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	// shadow of control, the rules hang on it
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			ctl <= 8'h00;
		else if (WR && ADDR == `TMRC_ADDR_CONTROL)
			ctl <= WDATA;
	sequence ctl_wr;
		WR && ADDR == `TMRC_ADDR_CONTROL;
	endsequence
	sequence event_hit;
		COMPARE_MATCH && COMPARE_MODE == `TMRC_SPECIAL_EVENT_MODE;
	endsequence
	rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside slot");
	std_base_a: assert property (ctl_wr |=> TB_STANDARD_SEL == $past(WDATA[6]))
		else $error("standard base wrong");
	enh_base_a: assert property (TB_STANDARD_SEL |-> TB_ENHANCED_SEL)
		else $error("enhanced base wrong");
	run_hold_a: assert property (!ctl[0] && !WR && !COMPARE_MATCH |=> $stable(COUNT_VALUE))
		else $error("count moved while stopped");
	timer_step_a: assert property (ctl[0] && !ctl[1] && ctl[5:4] == 2'h0 && !WR
		&& !COMPARE_MATCH |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
		else $error("timer step wrong");
	low_write_a: assert property (WR && ADDR == `TMRC_ADDR_COUNT_LOW
		|=> COUNT_VALUE[7:0] == $past(WDATA))
		else $error("low write lost");
	event_zero_a: assert property (event_hit ##0 (!WR && !(ctl[1] && ctl[2]))
		|=> COUNT_VALUE == 16'h0000)
		else $error("special event no reset");
	conv_start_a: assert property (event_hit ##0 CONVERTER_ENABLE |=> CONVERT_START)
		else $error("conversion not started");
	osc_pins_a: assert property (SHARED_OSCILLATOR_ENABLE
		|=> PIN_DIRECTION == 2'h3 && PIN_READ == 2'h0)
		else $error("pins not forced");
	irq_cause_a: assert property ($rose(IRQ)
		|-> COUNT_VALUE == 16'h0000 || $past(WR) || $past(WR, 2))
		else $error("irq without cause");
endmodule : tmrc_assertions
bind tmrc_timer tmrc_assertions tmrc_assertions_i (.*);

// >>> bench/tmrc_ext_src.sv
// model of external count pin or oscillator
// assumes the bench starts and stops it
`timescale 1ns/10ps
module tmrc_ext_src #(
	parameter int HALF = 37 // half period ns
) (
	input wire logic run, // cycles while high
	output logic pin // clock level
);
	initial
		pin = 1'b1;
	// whole periods only, so it rests high
	always
	begin
		wait (run);
		#(HALF) pin = 1'b0;
		#(HALF) pin = 1'b1;
	end
endmodule : tmrc_ext_src

// >>> bench/tb.sv
// self-checking bench of the timer
// assumes checker bound in its own file
`timescale 1ns/10ps
module tb;
	logic CORE_CLK = 1'b0;
	logic RSTN = 1'b0;
	logic CE = 1'b1;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic SHARED_OSCILLATOR_ENABLE = 1'b0;
	logic [3:0] COMPARE_MODE = 4'h0;
	logic COMPARE_MATCH = 1'b0;
	logic CONVERTER_ENABLE = 1'b0;
	logic [1:0] PORT_DIRECTION_BITS = 2'h1;
	logic [1:0] PORT_PIN_LEVEL = 2'h2;
	logic EXTERNAL_COUNT_PIN, SHARED_OSC_CLK, IRQ, CONVERT_START;
	logic TB_ENHANCED_SEL, TB_STANDARD_SEL;
	logic [7:0] RDATA;
	logic [1:0] PIN_DIRECTION, PIN_READ;
	logic [15:0] COUNT_VALUE, rv;
	logic go_pin = 1'b0;
	logic go_osc = 1'b0;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	int rises = 0;
	tmrc_timer tmrc_timer_i (.*);
	tmrc_ext_src #(.HALF(37)) pin_src_i (.run(go_pin), .pin(EXTERNAL_COUNT_PIN));
	tmrc_ext_src #(.HALF(53)) osc_src_i (.run(go_osc), .pin(SHARED_OSC_CLK));
	always #5 CORE_CLK = ~CORE_CLK;
	always @(posedge EXTERNAL_COUNT_PIN or posedge SHARED_OSC_CLK)
		rises++;
	always @(posedge CORE_CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1;
		d = {8'h00, RDATA};
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge CORE_CLK);
		#1;
	endtask : settle
	task automatic t_regs();
		rd(3'h0, rv);
		chk(rv, 16'h0000);
		rd(3'h7, rv);
		chk(rv, 16'h0000);
		wr(3'h5, 8'h02);
		rd(3'h5, rv);
		chk(rv, 16'h0002);
		wr(3'h0, 8'h48);
		settle();
		chk({TB_STANDARD_SEL, TB_ENHANCED_SEL}, 16'h0003);
		wr(3'h0, 8'h08);
		settle();
		chk({TB_STANDARD_SEL, TB_ENHANCED_SEL}, 16'h0001);
		chk(PIN_DIRECTION, 16'h0001);
	endtask : t_regs
	task automatic t_wide();
		wr(3'h0, 8'h80);
		wr(3'h2, 8'h12);
		settle();
		chk(COUNT_VALUE, 16'h0000);
		wr(3'h1, 8'h34);
		settle();
		chk(COUNT_VALUE, 16'h1234);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'hAB);
		settle();
		chk(COUNT_VALUE, 16'hAB34);
		wr(3'h0, 8'h80);
		wr(3'h2, 8'h77);
		rd(3'h1, rv);
		chk(rv, 16'h0034);
		rd(3'h2, rv);
		chk(rv, 16'h00AB);
	endtask : t_wide
	task automatic t_prescale();
		wr(3'h0, 8'h00);
		for (int ps = 0; ps < 4; ps++)
		begin
			wr(3'h2, 8'h00);
			wr(3'h1, 8'h00);
			wr(3'h0, {2'h0, ps[1:0], 4'h1});
			repeat (62) @(posedge CORE_CLK);
			wr(3'h0, 8'h00);
			settle();
			chk(COUNT_VALUE, 16'(64 >> ps));
		end
	endtask : t_prescale
	task automatic t_overflow();
		wr(3'h2, 8'hFF);
		wr(3'h1, 8'hFE);
		wr(3'h0, 8'h01);
		repeat (3) @(posedge CORE_CLK);
		wr(3'h0, 8'h00);
		settle();
		chk(COUNT_VALUE, 16'h0003);
		chk(IRQ, 16'h0001);
		wr(3'h5, 8'h00);
		settle();
		chk(IRQ, 16'h0000);
		rd(3'h3, rv);
		chk(rv, 16'h0002);
		wr(3'h4, 8'h02);
		rd(3'h3, rv);
		chk(rv, 16'h0000);
	endtask : t_overflow
	task automatic t_special();
		@(posedge CORE_CLK);
		COMPARE_MODE <= 4'hB;
		CONVERTER_ENABLE <= 1'b1;
		wr(3'h0, 8'h01);
		repeat (5) @(posedge CORE_CLK);
		COMPARE_MATCH <= 1'b1;
		@(posedge CORE_CLK);
		COMPARE_MATCH <= 1'b0;
		#1;
		chk(COUNT_VALUE, 16'h0000);
		chk(CONVERT_START, 16'h0001);
		@(posedge CORE_CLK);
		COMPARE_MATCH <= 1'b1;
		ADDR <= 3'h1;
		WDATA <= 8'h77;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		COMPARE_MATCH <= 1'b0;
		WR <= 1'b0;
		#1;
		chk(COUNT_VALUE, 16'h0077);
		wr(3'h2, 8'hFF);
		wr(3'h1, 8'hFF);
		COMPARE_MATCH <= 1'b1;
		@(posedge CORE_CLK);
		COMPARE_MATCH <= 1'b0;
		#1;
		chk(COUNT_VALUE, 16'h0000);
		wr(3'h0, 8'h00);
		rd(3'h3, rv);
		chk(rv, 16'h0000);
	endtask : t_special
	task automatic t_ext(input logic [7:0] c, input logic osc);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h00);
		wr(3'h1, 8'h00);
		SHARED_OSCILLATOR_ENABLE <= osc;
		wr(3'h0, c);
		rises = 0;
		go_pin = !osc;
		go_osc = osc;
		repeat (60) @(posedge CORE_CLK);
		go_pin = 1'b0;
		go_osc = 1'b0;
		repeat (20) @(posedge CORE_CLK);
		chk(COUNT_VALUE, 16'(rises));
		chk(PIN_DIRECTION, osc ? 16'h0003 : 16'h0001);
		chk(PIN_READ, osc ? 16'h0000 : 16'h0002);
	endtask : t_ext
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (16) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		t_regs();
		t_wide();
		t_prescale();
		t_overflow();
		t_special();
		t_ext(8'h03, 1'b0);
		t_ext(8'h07, 1'b0);
		t_ext(8'h03, 1'b1);
		tally_and_finish();
	end
endmodule : tb
